// file: logic/acc_top.sv
// Analog comparator control with AHB-Lite register slave
`timescale 1ns/10ps
`include "acc_params.svh"
module acc_top
	import acc_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk,
	input wire logic rst_b,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Comparator analog front end
	input wire logic compRaw,
	output logic compPowerDown,
	output logic bandgapSelect,
	output logic negFromMux,
	output logic [2:0] negChannel,
	// Pin input buffers and port read values
	input wire logic posPinRaw,
	input wire logic negPinRaw,
	output logic posPinBufOff,
	output logic negPinBufOff,
	output logic posPinRead,
	output logic negPinRead,
	// Timer capture and processor interrupt
	output logic captureTrigger,
	input wire logic irqVectorAck,
	output logic compIrqReq,
	output logic irq
);

	// ----------------------------------------
	// Reset release
	// ----------------------------------------
	logic rstMeta_q;
	logic rstSync_b;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rstMeta_q <= 1'b0;
			rstSync_b <= 1'b0;
		end
		else
		begin
			rstMeta_q <= 1'b1;
			rstSync_b <= rstMeta_q;
		end
	end

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [2:0] syncMeta_q;
	logic [2:0] sync_q;
	logic compSync;

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			syncMeta_q <= 3'h0;
			sync_q <= 3'h0;
		end
		else if (ce)
		begin
			syncMeta_q <= {negPinRaw, posPinRaw, compRaw};
			sync_q <= syncMeta_q;
		end
	end

	assign compSync = sync_q[0];

	// ----------------------------------------
	// Register storage
	// ----------------------------------------
	logic compDisable_q;
	logic bandgap_q;
	logic flag_q;
	logic irqEnable_q;
	logic capture_q;
	acc_mode_t mode_q;
	logic muxEnable_q;
	logic [3:0] convB_q;
	logic [1:0] digDisable_q;
	logic globalIe_q;
	logic convEnable_q;
	logic [2:0] channel_q;
	logic [`ACC_IRQ_BITS-1:0] irqStatus_q;
	logic [`ACC_IRQ_BITS-1:0] irqMask_q;

	// ----------------------------------------
	// Bus front end
	// ----------------------------------------
	acc_bus_state_t state_q;
	logic wrPend_q;
	logic [7:0] addrIdx_q;
	logic addrOk_q;
	logic rdPend_q;
	logic accept;
	logic wrStrobe;
	logic rdStrobe;
	logic [7:0] wrByte;

	function automatic logic hit(input logic ok, input logic [7:0] idx, input logic [7:0] reg_idx);
		hit = ok && (idx == reg_idx);
	endfunction : hit

	assign accept = hsel && hready && htrans[1] && hreadyout;
	assign wrStrobe = wrPend_q;
	assign rdStrobe = (state_q == ACC_BUS_RDWAIT);
	assign wrByte = hwdata[7:0];

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			state_q <= ACC_BUS_IDLE;
			wrPend_q <= 1'b0;
			rdPend_q <= 1'b0;
			addrIdx_q <= 8'h00;
			addrOk_q <= 1'b0;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else if (ce)
		begin
			hresp <= 1'b0;
			wrPend_q <= accept && hwrite;
			rdPend_q <= 1'b0;
			if (accept)
			begin
				addrIdx_q <= haddr[9:2];
				addrOk_q <= (haddr[31:10] == 22'h000000) && (haddr[1:0] == 2'h0);
			end
			case (state_q)
				ACC_BUS_IDLE:
				begin
					if (accept && !hwrite)
					begin
						state_q <= ACC_BUS_RDWAIT;
						hreadyout <= 1'b0;
					end
				end
				ACC_BUS_RDWAIT:
				begin
					state_q <= ACC_BUS_IDLE;
					hreadyout <= 1'b1;
					rdPend_q <= 1'b1;
				end
				default:
				begin
					state_q <= ACC_BUS_IDLE;
					hreadyout <= 1'b1;
				end
			endcase
		end
	end

	// ----------------------------------------
	// Read data, reserved bits zero
	// ----------------------------------------
	logic [7:0] rdByte;

	always_comb
	begin
		rdByte = 8'h00;
		if (hit(addrOk_q, addrIdx_q, `ACC_IDX_STATUS_CTRL))
			rdByte = {compDisable_q, bandgap_q, compSync, flag_q,
				irqEnable_q, capture_q, mode_q};
		else if (hit(addrOk_q, addrIdx_q, `ACC_IDX_CONV_CTRL_B))
			rdByte = {1'b0, muxEnable_q, 2'h0, convB_q};
		else if (hit(addrOk_q, addrIdx_q, `ACC_IDX_DIG_DISABLE))
			rdByte = {6'h00, digDisable_q};
		else if (hit(addrOk_q, addrIdx_q, `ACC_IDX_AUX_CTRL))
			rdByte = {3'h0, channel_q, convEnable_q, globalIe_q};
		else if (hit(addrOk_q, addrIdx_q, `ACC_IDX_IRQ_STATUS))
			rdByte = {6'h00, irqStatus_q};
		else if (hit(addrOk_q, addrIdx_q, `ACC_IDX_IRQ_MASK))
			rdByte = {6'h00, irqMask_q};
	end

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			hrdata <= 32'h00000000;
		else if (ce && rdStrobe)
			hrdata <= {24'h000000, rdByte};
	end

	// ----------------------------------------
	// Comparator status and control
	// ----------------------------------------
	logic wrSc;

	assign wrSc = wrStrobe && hit(addrOk_q, addrIdx_q, `ACC_IDX_STATUS_CTRL);

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			compDisable_q <= 1'b0;
			bandgap_q <= 1'b0;
			irqEnable_q <= 1'b0;
			capture_q <= 1'b0;
			mode_q <= ACC_MODE_TOGGLE;
		end
		else if (ce && wrSc)
		begin
			compDisable_q <= wrByte[`ACC_SC_DISABLE];
			bandgap_q <= wrByte[`ACC_SC_BANDGAP];
			irqEnable_q <= wrByte[`ACC_SC_IRQ_EN];
			capture_q <= wrByte[`ACC_SC_CAPTURE];
			mode_q <= acc_mode_t'(wrByte[`ACC_SC_MODE_HI:`ACC_SC_MODE_LO]);
		end
	end

	// ----------------------------------------
	// Event detection and interrupt flag
	// ----------------------------------------
	acc_evt_if evtIf ();

	assign evtIf.syncOut = compSync;
	assign evtIf.mode = mode_q;

	acc_event u_event
	(
		.clk(clk),
		.rstSync_b(rstSync_b),
		.ce(ce),
		.evt(evtIf.det)
	);

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			flag_q <= 1'b0;
		else if (ce)
		begin
			if (evtIf.modeEvt)
				flag_q <= 1'b1;
			else if (irqVectorAck)
				flag_q <= 1'b0;
			else if (wrSc && wrByte[`ACC_SC_FLAG])
				flag_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Converter control B, digital disable, auxiliary
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			muxEnable_q <= 1'b0;
			convB_q <= 4'h0;
			digDisable_q <= 2'h0;
			globalIe_q <= 1'b0;
			convEnable_q <= 1'b0;
			channel_q <= 3'h0;
			irqMask_q <= '0;
		end
		else if (ce && wrStrobe)
		begin
			if (hit(addrOk_q, addrIdx_q, `ACC_IDX_CONV_CTRL_B))
			begin
				muxEnable_q <= wrByte[`ACC_CB_MUX_EN];
				convB_q <= wrByte[`ACC_CB_CH_HIGH:0];
			end
			if (hit(addrOk_q, addrIdx_q, `ACC_IDX_DIG_DISABLE))
				digDisable_q <= wrByte[`ACC_DD_NEG:`ACC_DD_POS];
			if (hit(addrOk_q, addrIdx_q, `ACC_IDX_AUX_CTRL))
			begin
				globalIe_q <= wrByte[`ACC_AUX_GLOBAL_IE];
				convEnable_q <= wrByte[`ACC_AUX_CONV_EN];
				channel_q <= wrByte[`ACC_AUX_CH_HI:`ACC_AUX_CH_LO];
			end
			if (hit(addrOk_q, addrIdx_q, `ACC_IDX_IRQ_MASK))
				irqMask_q <= wrByte[`ACC_IRQ_BITS-1:0];
		end
	end

	// ----------------------------------------
	// Sticky interrupt status, cleared by read
	// ----------------------------------------
	logic [`ACC_IRQ_BITS-1:0] irqSet;
	logic rdIs;

	assign irqSet = {evtIf.toggleEvt, evtIf.modeEvt};
	assign rdIs = rdPend_q && hit(addrOk_q, addrIdx_q, `ACC_IDX_IRQ_STATUS);

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			irqStatus_q <= '0;
		else if (ce)
			irqStatus_q <= irqSet | (rdIs ? '0 : irqStatus_q);
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
		begin
			compPowerDown <= 1'b0;
			bandgapSelect <= 1'b0;
			negFromMux <= 1'b0;
			negChannel <= 3'h0;
			posPinBufOff <= 1'b0;
			negPinBufOff <= 1'b0;
			posPinRead <= 1'b0;
			negPinRead <= 1'b0;
			captureTrigger <= 1'b0;
			compIrqReq <= 1'b0;
			irq <= 1'b0;
		end
		else if (ce)
		begin
			compPowerDown <= compDisable_q;
			bandgapSelect <= bandgap_q;
			negFromMux <= muxEnable_q && !convEnable_q;
			negChannel <= channel_q;
			posPinBufOff <= digDisable_q[`ACC_DD_POS];
			negPinBufOff <= digDisable_q[`ACC_DD_NEG];
			posPinRead <= sync_q[1] && !digDisable_q[`ACC_DD_POS];
			negPinRead <= sync_q[2] && !digDisable_q[`ACC_DD_NEG];
			captureTrigger <= capture_q && compSync;
			compIrqReq <= flag_q && irqEnable_q && globalIe_q;
			irq <= |(irqStatus_q & irqMask_q);
		end
	end

endmodule : acc_top

// file: logic/acc_params.svh
// Offsets, field positions, reset values and timing counts of the comparator control block
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// ----------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------
`define ACC_IDX_STATUS_CTRL 8'h50
`define ACC_IDX_CONV_CTRL_B 8'h7B
`define ACC_IDX_DIG_DISABLE 8'h7F
`define ACC_IDX_AUX_CTRL 8'h60
`define ACC_IDX_IRQ_STATUS 8'h61
`define ACC_IDX_IRQ_MASK 8'h62

// ----------------------------------------
// Status and control fields
// ----------------------------------------
`define ACC_SC_DISABLE 7
`define ACC_SC_BANDGAP 6
`define ACC_SC_OUTPUT 5
`define ACC_SC_FLAG 4
`define ACC_SC_IRQ_EN 3
`define ACC_SC_CAPTURE 2
`define ACC_SC_MODE_HI 1
`define ACC_SC_MODE_LO 0

// ----------------------------------------
// Converter control B, digital disable, auxiliary fields
// ----------------------------------------
`define ACC_CB_MUX_EN 6
`define ACC_CB_CH_HIGH 3
`define ACC_CB_TRIG_HI 2
`define ACC_DD_NEG 1
`define ACC_DD_POS 0
`define ACC_AUX_GLOBAL_IE 0
`define ACC_AUX_CONV_EN 1
`define ACC_AUX_CH_LO 2
`define ACC_AUX_CH_HI 4
`define ACC_IS_FLAG_EVT 0
`define ACC_IS_TOGGLE 1

// ----------------------------------------
// Reset values and timing
// ----------------------------------------
`define ACC_RST_BYTE 8'h00
`define ACC_IRQ_BITS 2
`define ACC_READ_WAIT 1

`endif

// file: logic/acc_pkg.sv
// Types shared by the comparator control modules
package acc_pkg;

	typedef enum logic [1:0]
	{
		ACC_MODE_TOGGLE = 2'h0,
		ACC_MODE_RSVD = 2'h1,
		ACC_MODE_FALL = 2'h2,
		ACC_MODE_RISE = 2'h3
	} acc_mode_t;

	// Gray order along idle -> read wait -> idle
	typedef enum logic [1:0]
	{
		ACC_BUS_IDLE = 2'h0,
		ACC_BUS_RDWAIT = 2'h1
	} acc_bus_state_t;

endpackage : acc_pkg

// file: logic/acc_evt_if.sv
// Carrier between the control top and the event detector
`timescale 1ns/10ps
interface acc_evt_if;
	import acc_pkg::*;
	logic syncOut;
	acc_mode_t mode;
	logic modeEvt;
	logic toggleEvt;

	modport ctrl (output syncOut, output mode, input modeEvt, input toggleEvt);
	modport det (input syncOut, input mode, output modeEvt, output toggleEvt);
endinterface : acc_evt_if

// file: logic/acc_event.sv
// Edge detector that turns the synchronised comparator output into mode events
`timescale 1ns/10ps
module acc_event
	import acc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstSync_b,
	input wire logic ce,
	// Detector side of the carrier
	acc_evt_if.det evt
);

	logic prev_q;

	always_ff @(posedge clk or negedge rstSync_b)
	begin
		if (!rstSync_b)
			prev_q <= 1'b0;
		else if (ce)
			prev_q <= evt.syncOut;
	end

	always_comb
	begin
		evt.toggleEvt = evt.syncOut ^ prev_q;
		case (evt.mode)
			ACC_MODE_TOGGLE: evt.modeEvt = evt.syncOut ^ prev_q;
			ACC_MODE_FALL: evt.modeEvt = prev_q & ~evt.syncOut;
			ACC_MODE_RISE: evt.modeEvt = ~prev_q & evt.syncOut;
			ACC_MODE_RSVD: evt.modeEvt = 1'b0;
			default: evt.modeEvt = 1'b0;
		endcase
	end

endmodule : acc_event

// file: verif/acc_top_assertions.sv
// Checker of bus timing, pin reads and capture routing of the comparator control
`timescale 1ns/10ps
module acc_top_assertions
(
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Bus
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// Comparator and pins
	input wire logic compRaw,
	input wire logic compPowerDown,
	input wire logic posPinBufOff,
	input wire logic negPinBufOff,
	input wire logic posPinRead,
	input wire logic negPinRead,
	input wire logic captureTrigger
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	logic taken;
	logic wrTake;
	assign taken = hsel && hready && htrans[1] && hreadyout;
	assign wrTake = taken && hwrite;
	read_one_wait_a: assert property (taken && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait not one cycle");
	write_no_wait_a: assert property (wrTake |=> hreadyout)
		else $error("write inserted a wait");
	upper_zero_a: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	okay_resp_a: assert property (taken |=> !hresp ##1 !hresp)
		else $error("response not okay");
	pos_read_off_a: assert property (posPinBufOff && $past(posPinBufOff) |-> !posPinRead)
		else $error("positive pin read while disabled");
	neg_read_off_a: assert property (negPinBufOff && $past(negPinBufOff) |-> !negPinRead)
		else $error("negative pin read while disabled");
	capture_src_a: assert property (captureTrigger |-> $past(compRaw, 3))
		else $error("capture trigger without comparator high");
	power_by_write_a: assert property ($changed(compPowerDown) |-> $past(wrTake, 2) || $past(wrTake, 3))
		else $error("power down changed without a write");
	cover property (taken && !hwrite);
	cover property ($rose(captureTrigger));
	cover property ($rose(posPinBufOff));
endmodule : acc_top_assertions

bind acc_top acc_top_assertions u_chk (.clk(clk), .rst_b(rst_b), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
	.compRaw(compRaw), .compPowerDown(compPowerDown), .posPinBufOff(posPinBufOff),
	.negPinBufOff(negPinBufOff), .posPinRead(posPinRead), .negPinRead(negPinRead),
	.captureTrigger(captureTrigger));

// file: verif/acc_front_model.sv
// Comparator front end: raw output from the selected input levels
`timescale 1ns/10ps
module acc_front_model
#(
	parameter int BANDGAP_MV = 1100
)
(
	// Controls from the block
	input wire logic compPowerDown,
	input wire logic bandgapSelect,
	input wire logic negFromMux,
	input wire logic [2:0] negChannel,
	// Input levels in millivolts
	input int posMv,
	input int negMv,
	// Raw comparator output
	output logic compRaw
);
	int posIn;
	int negIn;
	always_comb
	begin
		posIn = bandgapSelect ? BANDGAP_MV : posMv;
		negIn = negFromMux ? 250 * negChannel : negMv;
		compRaw = !compPowerDown && (posIn > negIn);
	end
endmodule : acc_front_model

// file: verif/analog_comparator_control_tb_top.sv
// Self-checking bench of the comparator control block
`timescale 1ns/10ps
`include "acc_params.svh"
module analog_comparator_control_tb_top;
	localparam logic [31:0] SC = 32'h4 * `ACC_IDX_STATUS_CTRL;
	localparam logic [31:0] CB = 32'h4 * `ACC_IDX_CONV_CTRL_B;
	localparam logic [31:0] DD = 32'h4 * `ACC_IDX_DIG_DISABLE;
	localparam logic [31:0] AX = 32'h4 * `ACC_IDX_AUX_CTRL;
	localparam logic [31:0] IS = 32'h4 * `ACC_IDX_IRQ_STATUS;
	localparam logic [31:0] MK = 32'h4 * `ACC_IDX_IRQ_MASK;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic ce = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic posPinRaw = 1'b0;
	logic negPinRaw = 1'b0;
	logic irqVectorAck = 1'b0;
	logic timerCapIe = 1'b0;
	wire [31:0] hrdata;
	wire [2:0] negChannel;
	wire hreadyout, hresp, compRaw, compPowerDown, bandgapSelect, negFromMux;
	wire posPinBufOff, negPinBufOff, posPinRead, negPinRead, captureTrigger, compIrqReq, irq;
	wire hready = hreadyout;
	int num_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	int posMv = 0;
	int negMv = 1000;
	int i;
	int m;
	int off;
	logic [31:0] rd;
	int evq[$];

	acc_top DUT (.*);
	acc_front_model u_front (.*);

	always #2 clk = ~clk;

	task close_out;
		if (num_errors == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : close_out

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			num_errors++;
			close_out;
		end
	end

	task chk(input string n, input logic [31:0] s, input logic [31:0] e);
		num_checks++;
		if (s !== e)
		begin
			num_errors++;
			$display("mismatch %s exp %h seen %h", n, e, s);
		end
	endtask : chk

	task ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		do @(posedge clk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb

	task wr(input logic [31:0] a, input logic [31:0] d);
		ahb(1'b1, a, d);
	endtask : wr

	task rdc(input string n, input logic [31:0] a, input logic [31:0] e);
		ahb(1'b0, a, 32'h0);
		chk(n, rd, e);
	endtask : rdc

	task settle;
		repeat (5) @(posedge clk);
	endtask : settle

	// Status expected after an output edge in a given mode
	function automatic logic [31:0] expSc(int md, int up);
		logic f;
		f = (md == 0) || (md == 3 && up == 1) || (md == 2 && up == 0);
		return {26'h0, up[0], f, 2'h0, md[1:0]};
	endfunction : expSc

	initial
	begin
		rd = $urandom(32'hF4EC);
		off = $urandom % 8;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		rdc("status", SC, 32'h0);
		rdc("convb", CB, 32'h0);
		rdc("didr", DD, 32'h0);
		wr(CB, 32'hFF);
		rdc("convb", CB, 32'h4F);
		rdc("unmapped", 32'h3F0, 32'h0);
		for (i = 0; i < 8; i++)
		begin
			m = (i + off) % 8;
			wr(AX, m << 2);
			settle;
			chk("chan", negChannel, m);
			chk("mux", negFromMux, 1);
		end
		wr(AX, 32'h2);
		settle;
		chk("mux", negFromMux, 0);
		wr(AX, 32'h0);
		wr(CB, 32'h0);
		settle;
		chk("mux", negFromMux, 0);
		wr(SC, 32'hE0);
		settle;
		chk("power", compPowerDown, 1);
		chk("bandgap", bandgapSelect, 1);
		rdc("status", SC, 32'hC0);
		wr(SC, 32'h0);
		for (i = 0; i < 4; i++)
		begin
			posPinRaw <= 1'($urandom);
			negPinRaw <= 1'($urandom);
			wr(DD, i);
			settle;
			chk("posread", posPinRead, posPinRaw & !i[0]);
			chk("negread", negPinRead, negPinRaw & !i[1]);
			chk("bufoff", {negPinBufOff, posPinBufOff}, i);
		end
		wr(AX, 32'h1);
		for (m = 0; m < 4; m++)
		begin
			wr(SC, 32'h10 | m);
			for (i = 1; i >= 0; i--)
			begin
				posMv <= i * 2000;
				evq.push_back(i);
				settle;
				rdc("flag", SC, expSc(m, evq.pop_front()));
				wr(SC, m);
				rdc("flag", SC, expSc(m, i));
				wr(SC, 32'h10 | m);
				rdc("flag", SC, {26'h0, i[0], 5'h0} | m);
			end
		end
		wr(SC, 32'h1B);
		posMv <= 2000;
		settle;
		chk("irqreq", compIrqReq, 1);
		irqVectorAck <= 1'b1;
		@(posedge clk);
		irqVectorAck <= 1'b0;
		settle;
		chk("irqreq", compIrqReq, 0);
		rdc("status", SC, 32'h2B);
		posMv <= 0;
		settle;
		posMv <= 2000;
		settle;
		wr(AX, 32'h0);
		settle;
		chk("irqreq", compIrqReq, 0);
		wr(SC, 32'h04);
		timerCapIe <= 1'b1;
		settle;
		chk("capture", captureTrigger, 1);
		chk("capirq", captureTrigger & timerCapIe, 1);
		posMv <= 0;
		settle;
		chk("capture", captureTrigger, 0);
		posMv <= 2000;
		wr(SC, 32'h0);
		settle;
		chk("capture", captureTrigger, 0);
		ahb(1'b0, IS, 32'h0);
		wr(MK, 32'h0);
		posMv <= 0;
		settle;
		chk("irq", irq, 0);
		wr(MK, 32'h3);
		settle;
		chk("irq", irq, 1);
		rdc("irqstat", IS, 32'h3);
		settle;
		chk("irq", irq, 0);
		ce <= 1'b0;
		posMv <= 2000;
		settle;
		chk("freeze", irq, 0);
		ce <= 1'b1;
		settle;
		chk("irq", irq, 1);
		close_out;
	end
endmodule : analog_comparator_control_tb_top
